/* File: rail_enable_map.vh */
`ifndef RAIL_ENABLE_MAP_VH
`define RAIL_ENABLE_MAP_VH

// ============================================================
// register offsets
`define SWITCH_TERM_DISABLE_OFFS 8'h9F
`define RAIL_FORCE_FIRST_OFFS 8'hA0

// ============================================================
// reset values
`define SWITCH_TERM_DISABLE_RST 8'hF0
`define RAIL_FORCE_FIRST_RST 8'h00
`define READ_IDLE_DATA 8'h00

// ============================================================
// switch/termination disable fields
`define SHARED_SLOT_KILL_BIT 7
`define SWITCH_B_FIRST_KILL_BIT 6
`define SWITCH_A_FIRST_KILL_BIT 5
`define TERMINATION_KILL_BIT 4
`define RESERVED_MSB 3
`define RESERVED_LSB 0

// ============================================================
// rail force fields
`define LINREG_A_SECOND_FORCE_BIT 7
`define SWITCH_A_FIRST_FORCE_BIT 6
`define CONVERTER_FORCE_MSB 5
`define CONVERTER_FORCE_LSB 0

// ============================================================
// rail indices inside the internal rail vectors
`define RAIL_COUNT 11
`define RAIL_CONV_ONE 0
`define RAIL_CONV_TWO 1
`define RAIL_CONV_THREE 2
`define RAIL_CONV_FOUR 3
`define RAIL_CONV_FIVE 4
`define RAIL_CONV_SIX 5
`define RAIL_CONVERTERS 6
`define RAIL_SWITCH_A_FIRST 6
`define RAIL_LINREG_A_SECOND 7
`define RAIL_SWITCH_B_FIRST 8
`define RAIL_SHARED_SLOT 9
`define RAIL_TERMINATION 10

// ============================================================
// source select codes for each rail
`define SRC_WIDTH 3
`define SRC_PG 3'h7
`define PIN_COUNT 6

`endif

/* File: pin_sync.v */
// ============================================================
// two-flop synchroniser for the control input pins
module pin_sync #(
    parameter WIDTH = 6
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // asynchronous pins in, synchronous copy out
    input wire [WIDTH-1:0] pins_async,
    output reg [WIDTH-1:0] pins_sync
);

reg [WIDTH-1:0] meta_r;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        meta_r <= {WIDTH{1'b0}};
        pins_sync <= {WIDTH{1'b0}};
    end else begin
        meta_r <= pins_async;
        pins_sync <= meta_r;
    end
end

endmodule

/* File: rail_gate.v */
`include "rail_enable_map.vh"

// ============================================================
// one rail: kill gates the OR of force and its assigned request
module rail_gate #(
    parameter [`SRC_WIDTH-1:0] SRC = `SRC_PG
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // controls
    input wire kill_n,
    input wire force_on,
    input wire [`PIN_COUNT-1:0] pins,
    input wire pg_req,
    // registered rail enable
    output reg rail_en_r
);

wire req;

// pin codes at or above the pin count fall back to the power-good chain;
// chosen at elaboration so no pin index can fall out of range
generate
    if (SRC < `PIN_COUNT) begin : g_pin
        assign req = pins[SRC];
    end else begin : g_pg
        assign req = pg_req;
    end
endgenerate

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        rail_en_r <= 1'b0;
    end else begin
        rail_en_r <= kill_n & (force_on | req);
    end
end

endmodule

/* File: rail_enable_override_regs.v */
// Notes on behaviour
// - shared-slot kill bit 7 zero holds rail off
// - factory setting picks switch or regulator for slot
// - bit 6 zero keeps first B switch off
// - bit 5 zero keeps first A switch off
// - bit 4 zero keeps termination regulator off
// - force bit 7 turns second A regulator on
// - force bit 6 turns first A switch on
// - force bit 5 turns converter six on
// - force bit 4 turns converter five on
// - force bit 3 turns converter four on
// - force bit 2 turns converter three on
// - force bit 1 turns converter two on
// - force bit 0 turns converter one on
// - unforced rail follows its pin or power-good
// - converters one to six killed by control bits
`include "rail_enable_map.vh"

module rail_enable_override_regs #(
    parameter [7:0] FORCE_RESET = `RAIL_FORCE_FIRST_RST,
    // source per rail, index 0..5 a pin, 7 the power-good chain
    parameter [`RAIL_COUNT*`SRC_WIDTH-1:0] RAIL_SRC =
        {`RAIL_COUNT{`SRC_PG}}
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register port from the serial host interface
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // factory setting: 1 selects the second B switch for the slot
    input wire otp_shared_is_switch,
    // kill bits held in other registers
    input wire [5:0] converter_kill,
    input wire linreg_a_second_kill,
    // force bits held in the second force register
    input wire switch_b_first_force,
    input wire shared_slot_force,
    input wire termination_force,
    // enable sources
    input wire [`PIN_COUNT-1:0] control_input_pins,
    input wire [`RAIL_COUNT-1:0] power_good_signal,
    // rail enables
    output reg [5:0] converter_en,
    output reg switch_a_first_en,
    output reg linreg_a_second_en,
    output reg switch_b_first_en,
    output reg switch_b_second_en,
    output reg linreg_a_first_en,
    output reg memory_termination_regulator_en
);

// ============================================================
// registers
reg [7:0] switch_termination_disable_r;
reg [7:0] rail_force_on_first_r;
reg shared_sel_r;
reg shared_sel_loaded_r;
wire [`PIN_COUNT-1:0] pins_s;
wire [`RAIL_COUNT-1:0] kill_n;
wire [`RAIL_COUNT-1:0] force_on;
wire [`RAIL_COUNT-1:0] rail_en;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        switch_termination_disable_r <= `SWITCH_TERM_DISABLE_RST;
        rail_force_on_first_r <= FORCE_RESET;
    end else if (reg_wr) begin
        // reserved nibble is stored as written; host keeps it zero
        if (reg_addr == `SWITCH_TERM_DISABLE_OFFS) begin
            switch_termination_disable_r <= reg_wdata;
        end
        if (reg_addr == `RAIL_FORCE_FIRST_OFFS) begin
            rail_force_on_first_r <= reg_wdata;
        end
    end
end

// ============================================================
// read port, one cycle after the strobe
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= `READ_IDLE_DATA;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                `SWITCH_TERM_DISABLE_OFFS: begin
                    reg_rdata <= switch_termination_disable_r;
                end
                `RAIL_FORCE_FIRST_OFFS: begin
                    reg_rdata <= rail_force_on_first_r;
                end
                default: begin
                    reg_rdata <= `READ_IDLE_DATA;
                end
            endcase
        end
    end
end

// ============================================================
// factory slot select, caught once after reset release
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        shared_sel_r <= 1'b0;
        shared_sel_loaded_r <= 1'b0;
    end else if (!shared_sel_loaded_r) begin
        shared_sel_r <= otp_shared_is_switch;
        shared_sel_loaded_r <= 1'b1;
    end
end

// ============================================================
// pin synchroniser
pin_sync #(
    .WIDTH(`PIN_COUNT)
) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins_async(control_input_pins),
    .pins_sync(pins_s)
);

// ============================================================
// kill and force vectors, one bit per rail
assign kill_n[`RAIL_CONVERTERS-1:0] = converter_kill;
assign kill_n[`RAIL_SWITCH_A_FIRST] =
    switch_termination_disable_r[`SWITCH_A_FIRST_KILL_BIT];
assign kill_n[`RAIL_LINREG_A_SECOND] = linreg_a_second_kill;
assign kill_n[`RAIL_SWITCH_B_FIRST] =
    switch_termination_disable_r[`SWITCH_B_FIRST_KILL_BIT];
assign kill_n[`RAIL_SHARED_SLOT] =
    switch_termination_disable_r[`SHARED_SLOT_KILL_BIT];
assign kill_n[`RAIL_TERMINATION] =
    switch_termination_disable_r[`TERMINATION_KILL_BIT];

// bits 0..5 map to converters one to six
assign force_on[`RAIL_CONVERTERS-1:0] =
    rail_force_on_first_r[`CONVERTER_FORCE_MSB:`CONVERTER_FORCE_LSB];
assign force_on[`RAIL_SWITCH_A_FIRST] =
    rail_force_on_first_r[`SWITCH_A_FIRST_FORCE_BIT];
assign force_on[`RAIL_LINREG_A_SECOND] =
    rail_force_on_first_r[`LINREG_A_SECOND_FORCE_BIT];
assign force_on[`RAIL_SWITCH_B_FIRST] = switch_b_first_force;
assign force_on[`RAIL_SHARED_SLOT] = shared_slot_force;
assign force_on[`RAIL_TERMINATION] = termination_force;

// ============================================================
// per-rail gating
// one named instance per rail, so each rail's gate is easy to trace
rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_ONE*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_one (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_ONE]),
    .force_on(force_on[`RAIL_CONV_ONE]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_ONE]),
    .rail_en_r(rail_en[`RAIL_CONV_ONE])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_TWO*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_two (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_TWO]),
    .force_on(force_on[`RAIL_CONV_TWO]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_TWO]),
    .rail_en_r(rail_en[`RAIL_CONV_TWO])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_THREE*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_three (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_THREE]),
    .force_on(force_on[`RAIL_CONV_THREE]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_THREE]),
    .rail_en_r(rail_en[`RAIL_CONV_THREE])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_FOUR*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_four (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_FOUR]),
    .force_on(force_on[`RAIL_CONV_FOUR]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_FOUR]),
    .rail_en_r(rail_en[`RAIL_CONV_FOUR])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_FIVE*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_five (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_FIVE]),
    .force_on(force_on[`RAIL_CONV_FIVE]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_FIVE]),
    .rail_en_r(rail_en[`RAIL_CONV_FIVE])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_CONV_SIX*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_conv_six (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_CONV_SIX]),
    .force_on(force_on[`RAIL_CONV_SIX]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_CONV_SIX]),
    .rail_en_r(rail_en[`RAIL_CONV_SIX])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_SWITCH_A_FIRST*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_switch_a_first (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_SWITCH_A_FIRST]),
    .force_on(force_on[`RAIL_SWITCH_A_FIRST]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_SWITCH_A_FIRST]),
    .rail_en_r(rail_en[`RAIL_SWITCH_A_FIRST])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_LINREG_A_SECOND*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_linreg_a_second (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_LINREG_A_SECOND]),
    .force_on(force_on[`RAIL_LINREG_A_SECOND]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_LINREG_A_SECOND]),
    .rail_en_r(rail_en[`RAIL_LINREG_A_SECOND])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_SWITCH_B_FIRST*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_switch_b_first (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_SWITCH_B_FIRST]),
    .force_on(force_on[`RAIL_SWITCH_B_FIRST]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_SWITCH_B_FIRST]),
    .rail_en_r(rail_en[`RAIL_SWITCH_B_FIRST])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_SHARED_SLOT*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_shared_slot (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_SHARED_SLOT]),
    .force_on(force_on[`RAIL_SHARED_SLOT]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_SHARED_SLOT]),
    .rail_en_r(rail_en[`RAIL_SHARED_SLOT])
);

rail_gate #(
    .SRC(RAIL_SRC[`RAIL_TERMINATION*`SRC_WIDTH +: `SRC_WIDTH])
) u_gate_termination (
    .clock(clock),
    .rst_n(rst_n),
    .kill_n(kill_n[`RAIL_TERMINATION]),
    .force_on(force_on[`RAIL_TERMINATION]),
    .pins(pins_s),
    .pg_req(power_good_signal[`RAIL_TERMINATION]),
    .rail_en_r(rail_en[`RAIL_TERMINATION])
);

// ============================================================
// output stage; keeps every output on a flop
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        converter_en <= 6'h00;
        switch_a_first_en <= 1'b0;
        linreg_a_second_en <= 1'b0;
        switch_b_first_en <= 1'b0;
        switch_b_second_en <= 1'b0;
        linreg_a_first_en <= 1'b0;
        memory_termination_regulator_en <= 1'b0;
    end else begin
        converter_en <= rail_en[`RAIL_CONVERTERS-1:0];
        switch_a_first_en <= rail_en[`RAIL_SWITCH_A_FIRST];
        linreg_a_second_en <= rail_en[`RAIL_LINREG_A_SECOND];
        switch_b_first_en <= rail_en[`RAIL_SWITCH_B_FIRST];
        // unselected slot target stays off
        switch_b_second_en <= shared_sel_r &
            rail_en[`RAIL_SHARED_SLOT];
        linreg_a_first_en <= ~shared_sel_r &
            rail_en[`RAIL_SHARED_SLOT];
        memory_termination_regulator_en <= rail_en[`RAIL_TERMINATION];
    end
end

endmodule

/* File: rail_monitor.sv */
module rail_monitor (
    // clock, reset and register port
    input wire clock,
    input wire rst_n,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    // rail controls and enables
    input wire otp_shared_is_switch,
    input wire [5:0] converter_kill,
    input wire linreg_a_second_kill,
    input wire [10:0] power_good_signal,
    input wire [5:0] converter_en,
    input wire linreg_a_second_en,
    input wire switch_b_second_en,
    input wire linreg_a_first_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // rail enables, two edges behind their causes
    a_conv_kill_off: assert property (
        (converter_en & ~$past(converter_kill) & ~$past(converter_kill, 2))
        == 6'h00) else $error("converter on while killed");
    a_conv_req_on: assert property (
        ((power_good_signal[5:0] & converter_kill) == 6'h3F) [*2]
        |=> converter_en == 6'h3F) else $error("converter not on");
    a_lra2_kill_off: assert property (
        !linreg_a_second_kill [*2] |=> !linreg_a_second_en)
        else $error("regulator on while killed");
    a_lra2_req_on: assert property (
        (power_good_signal[7] && linreg_a_second_kill) [*2]
        |=> linreg_a_second_en) else $error("regulator not on");
    a_slot_is_switch: assert property (
        otp_shared_is_switch |-> !linreg_a_first_en)
        else $error("unselected slot regulator on");
    a_slot_is_ldo: assert property (
        !otp_shared_is_switch |-> !switch_b_second_en)
        else $error("unselected slot switch on");
    // ============================================================
    // register read answers
    a_read_answer: assert property (
        reg_rvalid == $past(reg_rd)) else $error("read valid misplaced");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr != 8'h9F && reg_addr != 8'hA0
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
endmodule

bind rail_enable_override_regs rail_monitor mon_u (
    .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .otp_shared_is_switch(otp_shared_is_switch),
    .converter_kill(converter_kill),
    .linreg_a_second_kill(linreg_a_second_kill),
    .power_good_signal(power_good_signal), .converter_en(converter_en),
    .linreg_a_second_en(linreg_a_second_en),
    .switch_b_second_en(switch_b_second_en),
    .linreg_a_first_en(linreg_a_first_en));

/* File: host_model.sv */
module host_model (
    // clock
    input wire clock,
    // register port toward the device
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // ============================================================
    // accesses; released lines show junk, not the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == 8'h9F) ? (d & 8'hF0) : d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        // a missing valid spoils the value so the compare trips
        d = reg_rvalid ? reg_rdata : ~reg_rdata;
    endtask
endmodule

/* File: rail_enable_override_regs_bench.sv */
module rail_enable_override_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    wire reg_wr, reg_rd;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_rvalid;
    wire [11:0] rails;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] rd_val;
    logic [5:0] converter_kill = 6'h3F;
    logic linreg_a_second_kill = 1'b1;
    logic [2:0] f2 = 3'h0;
    logic otp = 1'b0;
    logic [5:0] pins = 6'h00;
    // rails 6, 8, 9, 10 follow pins 0..3, the rest power-good
    localparam logic [32:0] SRC_MAP =
        {3'h3, 3'h2, 3'h1, 3'h7, 3'h0, {6{3'h7}}};
    logic [10:0] power_good_signal = 11'h000;
    logic [11:0] kmap [4:7] = '{12'h800, 12'h040, 12'h100, 12'h400};
    int n_mismatch = 0;
    int tests_run = 0;
    always #50 clock = ~clock;
    host_model host_u (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    rail_enable_override_regs #(.RAIL_SRC(SRC_MAP)) dut_u (.clock(clock),
        .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .otp_shared_is_switch(otp), .converter_kill(converter_kill),
        .linreg_a_second_kill(linreg_a_second_kill),
        .switch_b_first_force(f2[0]), .shared_slot_force(f2[1]),
        .termination_force(f2[2]), .control_input_pins(pins),
        .power_good_signal(power_good_signal),
        .converter_en(rails[5:0]), .switch_a_first_en(rails[6]),
        .linreg_a_second_en(rails[7]), .switch_b_first_en(rails[8]),
        .switch_b_second_en(rails[9]), .linreg_a_first_en(rails[10]),
        .memory_termination_regulator_en(rails[11]));
    // ============================================================
    // helpers
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ============================================================
    // tests
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        host_u.rd(8'h9F, rd_val);
        check({4'h0, rd_val}, 12'h0F0);
        host_u.rd(8'hA0, rd_val);
        check({4'h0, rd_val}, 12'h000);
        host_u.wr(8'hA0, 8'h5A);
        host_u.wr(8'h3C, 8'hFF);
        host_u.rd(8'h3C, rd_val);
        check({4'h0, rd_val}, 12'h000);
        host_u.rd(8'hA0, rd_val);
        check({4'h0, rd_val}, 12'h05A);
        for (int i = 0; i < 8; i++) begin
            host_u.wr(8'hA0, 8'h01 << i);
            settle();
            check(rails, 12'h001 << i);
        end
        host_u.wr(8'hA0, 8'hFF);
        converter_kill <= 6'h2A;
        linreg_a_second_kill <= 1'b0;
        settle();
        check(rails, 12'h06A);
        converter_kill <= 6'h3F;
        linreg_a_second_kill <= 1'b1;
        f2 <= 3'h7;
        settle();
        check(rails, 12'hDFF);
        for (int i = 4; i < 8; i++) begin
            host_u.wr(8'h9F, 8'hF0 ^ (8'h01 << i));
            settle();
            check(rails, 12'hDFF & ~kmap[i]);
        end
        host_u.wr(8'h9F, 8'hF0);
        host_u.wr(8'hA0, 8'h00);
        f2 <= 3'h0;
        power_good_signal <= 11'h7FF;
        settle();
        check(rails, 12'h0BF);
        pins <= 6'h0F;
        settle();
        check(rails, 12'hDFF);
        power_good_signal <= 11'h000;
        settle();
        check(rails, 12'hD40);
        pins <= 6'h00;
        settle();
        check(rails, 12'h000);
        host_u.wr(8'hA0, 8'h81);
        // second reset, slot strapped to the switch this time
        otp <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        host_u.rd(8'hA0, rd_val);
        check({4'h0, rd_val}, 12'h000);
        f2 <= 3'h2;
        settle();
        check(rails, 12'h200);
        host_u.wr(8'h9F, 8'h70);
        settle();
        check(rails, 12'h000);
        end_of_test();
    end
    // a hang costs a mismatch; the run needs well under 1000 cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
